// [design/nand_ecc_regs.vh]
// constants of the page-buffer error-correction block
// assumes column addresses of 13 bits and 8-bit feature bytes
`ifndef NAND_ECC_REGS_VH
`define NAND_ECC_REGS_VH

// ----------------------------------------------------------------
// feature addresses
// ----------------------------------------------------------------
`define FA_THRESHOLD      8'h10
`define FA_SECTOR_FLAGS   8'h20
`define FA_WORST          8'h30
`define FA_COUNT_S10      8'h40
`define FA_COUNT_S32      8'h41
`define FA_COUNT_S54      8'h50
`define FA_COUNT_S76      8'h51
`define FA_CONFIG         8'hB0
`define FA_STATUS         8'hC0

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CFG_ECC_EN_BIT    4
`define ST_ECC_LSB        4
`define THR_LSB           0
`define THR_RESET         4'h4
`define THR_RESERVED      4'h0
`define ECC_EN_RESET      1'b1
`define WORST_CNT_LSB     4

// ----------------------------------------------------------------
// correction status codes and flip counts
// ----------------------------------------------------------------
`define ST_NO_ERROR       2'h0
`define ST_CORRECTED      2'h1
`define ST_UNCORRECTABLE  2'h2
`define FLIP_MAX_FIX      4'h8
`define FLIP_UNCORR       4'hf

// ----------------------------------------------------------------
// page layout
// ----------------------------------------------------------------
`define COL_SPARE_BASE    13'h1000
`define COL_PARITY_BASE   13'h1080
`define COL_PAGE_END_DIS  13'h1100
`define PARITY_BYTES      8'h80
`define PARITY_POLY       128'h8000_0000_0000_0000_0000_0000_0000_0087
`endif

// [design/ecc_parity_step.v]
// one byte step of the 128-bit parity remainder of a sector
// assumes bytes are folded most significant bit first
`timescale 1ns/10ps
`include "nand_ecc_regs.vh"

module ecc_parity_step (
	input  wire [127:0] state_i,
	input  wire [7:0]   data_i,
	output reg  [127:0] next_o
);
	integer k;
	reg     fb;

	always @* begin
		next_o = state_i;
		fb     = 1'b0;
		for (k = 7; k >= 0; k = k - 1) begin
			fb     = next_o[127] ^ data_i[k];
			next_o = {next_o[126:0], 1'b0} ^ (fb ? `PARITY_POLY : 128'h0000_0000_0000_0000_0000_0000_0000_0000);
		end
	end
endmodule // ecc_parity_step

// [design/nand_page_ecc.v]
// internal error correction of the page buffer: parity on program,
// correction and flip reporting on read, feature-table locations
// assumes one clock; command decode and array sequencing lie outside
//
// Behaviour
// (R1) parity computed over written data during program busy when enabled
// (R2) per sector up to eight flips corrected, nine or more detected
// (R3) 512 main bytes and 16 spare bytes form one parity unit
// (R4) sector n: main n*512..n*512+511, spare 4096+16n..4111+16n
// (R5) read data corrected inside; status held until next valid command
// (R6) parity at columns 4224..4351, host denied them while enabled
// (R7) host writes main and spare of a sector in one program
// (R8) correction enabled after power-on without configuration
// (R9) enable is bit 4 of feature B0h; zero disables correction
// (R10) disabled correction widens host spare area from 128 to 256 bytes
// (R11) host writes enable just before next read, program or erase
// (R12) overall status in bits 5:4 of feature C0h
// (R13) four-bit flip threshold at feature 10h set by feature write
// (R14) codes 1..8 select flips, 1111 uncorrectable, 0000 reserved, default 0100
// (R15) eight sector flags at feature 20h updated on buffer output
// (R16) flag set when sector count reaches threshold, else clear
// (R17) worst count and its sector at 30h, lowest sector wins ties
// (R18) four-bit sector counts at 40h and 50h, 1111 means uncorrected
// (R19) host issues only feature read or reset while busy
// (R20) status codes separate no error, corrected and uncorrectable
`timescale 1ns/10ps
`include "nand_ecc_regs.vh"

module nand_page_ecc (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire        feat_wr_i,
	input  wire        feat_rd_i,
	input  wire [7:0]  feat_addr_i,
	input  wire [7:0]  feat_wdata_i,
	output reg  [7:0]  feat_rdata_o,
	output reg         feat_rvalid_o,
	input  wire        cmd_accept_i,
	input  wire        prog_start_i,
	input  wire        prog_valid_i,
	input  wire [12:0] prog_col_i,
	input  wire [7:0]  prog_data_i,
	input  wire        prog_done_i,
	output reg         par_valid_o,
	output reg  [12:0] par_col_o,
	output reg  [7:0]  par_data_o,
	output wire        busy_o,
	input  wire        read_start_i,
	input  wire        rd_valid_i,
	input  wire [12:0] rd_col_i,
	input  wire [7:0]  rd_data_i,
	input  wire [7:0]  rd_err_i,
	input  wire        rd_done_i,
	output reg         cor_valid_o,
	output reg  [12:0] cor_col_o,
	output reg  [7:0]  cor_data_o,
	input  wire        buf_out_i,
	input  wire [12:0] host_col_i,
	output wire        host_col_ok_o,
	output wire        ecc_en_o
);
	// ----------------------------------------------------------------
	// states and helpers
	// ----------------------------------------------------------------
	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_PROG = 2'b01;
	localparam [1:0] S_EMIT = 2'b10;

	// (R4) sector of column
	function [2:0] sector_of;
		input [12:0] col;
		begin
			sector_of = (col < `COL_SPARE_BASE) ? col[11:9] : col[6:4];
		end
	endfunction

	// (R3) main or matching spare byte
	function in_codeword;
		input [12:0] col;
		begin
			in_codeword = (col < `COL_PARITY_BASE);
		end
	endfunction

	function [3:0] popcount;
		input [7:0] v;
		integer j;
		begin
			popcount = 4'h0;
			for (j = 0; j < 8; j = j + 1)
				popcount = popcount + {3'b000, v[j]};
		end
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg rst_meta;
	reg rst_n;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// feature registers
	// ----------------------------------------------------------------
	reg        ecc_en;
	reg [3:0]  threshold;
	reg [1:0]  ecc_status;
	reg [7:0]  sector_flip_flags;
	reg [3:0]  sector_flip_count [0:7];
	reg [3:0]  worst_flip_count;
	reg [2:0]  worst_sector_index;
	reg [3:0]  next_worst_cnt;
	reg [2:0]  next_worst_idx;
	reg [1:0]  next_status;
	integer    n;
	integer    ri;
	integer    si;
	integer    fi;

	assign ecc_en_o = ecc_en;

	// (R6) parity columns hidden while enabled
	// (R10) spare widens to 256 bytes when disabled
	assign host_col_ok_o = ecc_en ? (host_col_i < `COL_PARITY_BASE) : (host_col_i < `COL_PAGE_END_DIS);

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			// (R8) enabled from power-on
			ecc_en    <= `ECC_EN_RESET;
			// (R14) default threshold
			threshold <= `THR_RESET;
		end else if (feat_wr_i) begin
			// (R9) enable flag write
			if (feat_addr_i == `FA_CONFIG)
				ecc_en <= feat_wdata_i[`CFG_ECC_EN_BIT];
			// (R13) threshold write, reserved code ignored
			if (feat_addr_i == `FA_THRESHOLD && feat_wdata_i[`THR_LSB +: 4] != `THR_RESERVED)
				threshold <= feat_wdata_i[`THR_LSB +: 4];
		end
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			feat_rdata_o  <= 8'h00;
			feat_rvalid_o <= 1'b0;
		end else begin
			feat_rvalid_o <= feat_rd_i;
			if (feat_rd_i) begin
				case (feat_addr_i)
					`FA_CONFIG:       feat_rdata_o <= {3'b000, ecc_en, 4'h0};
					`FA_THRESHOLD:    feat_rdata_o <= {4'h0, threshold};
					// (R12) status field
					`FA_STATUS:       feat_rdata_o <= {2'b00, ecc_status, 4'h0};
					`FA_SECTOR_FLAGS: feat_rdata_o <= sector_flip_flags;
					// (R17) worst sector report
					`FA_WORST:        feat_rdata_o <= {worst_flip_count, 1'b0, worst_sector_index};
					// (R18) counts, two sectors a byte
					`FA_COUNT_S10:    feat_rdata_o <= {sector_flip_count[1], sector_flip_count[0]};
					`FA_COUNT_S32:    feat_rdata_o <= {sector_flip_count[3], sector_flip_count[2]};
					`FA_COUNT_S54:    feat_rdata_o <= {sector_flip_count[5], sector_flip_count[4]};
					`FA_COUNT_S76:    feat_rdata_o <= {sector_flip_count[7], sector_flip_count[6]};
					default:          feat_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// program: parity accumulation and emission
	// ----------------------------------------------------------------
	reg  [1:0]   state;
	reg  [127:0] par_acc [0:7];
	reg  [6:0]   emit_idx;
	wire [2:0]   prog_sec = sector_of(prog_col_i);
	wire [127:0] par_next;

	ecc_parity_step u_step (
		.state_i (par_acc[prog_sec]),
		.data_i  (prog_data_i),
		.next_o  (par_next)
	);

	assign busy_o = (state != S_IDLE);

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state       <= S_IDLE;
			emit_idx    <= 7'h00;
			par_valid_o <= 1'b0;
			par_col_o   <= 13'h0000;
			par_data_o  <= 8'h00;
			for (n = 0; n < 8; n = n + 1)
				par_acc[n] <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
		end else begin
			par_valid_o <= 1'b0;
			case (state)
				S_IDLE: begin
					if (prog_start_i) begin
						for (n = 0; n < 8; n = n + 1)
							par_acc[n] <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
						state <= S_PROG;
					end
				end
				S_PROG: begin
					// (R1) fold written bytes only while enabled
					if (prog_valid_i && ecc_en && in_codeword(prog_col_i))
						par_acc[prog_sec] <= par_next;
					if (prog_done_i) begin
						emit_idx <= 7'h00;
						state    <= ecc_en ? S_EMIT : S_IDLE;
					end
				end
				S_EMIT: begin
					// (R6) parity bytes land at 4224 upward
					par_valid_o <= 1'b1;
					par_col_o   <= `COL_PARITY_BASE + {6'h00, emit_idx};
					par_data_o  <= par_acc[emit_idx[6:4]][{emit_idx[3:0], 3'b000} +: 8];
					emit_idx    <= emit_idx + 7'h01;
					if (emit_idx == (`PARITY_BYTES - 8'h01))
						state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read: correction and flip counting
	// ----------------------------------------------------------------
	wire [2:0] rd_sec  = sector_of(rd_col_i);
	wire [3:0] rd_old  = sector_flip_count[rd_sec];
	wire [4:0] rd_sum  = {1'b0, rd_old} + {1'b0, popcount(rd_err_i)};
	// (R2) nine or more flips saturate as uncorrectable
	wire       rd_bad  = (rd_old == `FLIP_UNCORR) || (rd_sum > {1'b0, `FLIP_MAX_FIX});
	wire       rd_use  = ecc_en && in_codeword(rd_col_i);

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cor_valid_o <= 1'b0;
			cor_col_o   <= 13'h0000;
			cor_data_o  <= 8'h00;
			for (ri = 0; ri < 8; ri = ri + 1)
				sector_flip_count[ri] <= 4'h0;
		end else begin
			cor_valid_o <= rd_valid_i;
			if (rd_valid_i) begin
				cor_col_o <= rd_col_i;
				// (R5) correct in place; a sector passes raw from the byte that makes it uncorrectable
				cor_data_o <= (rd_use && !rd_bad) ? (rd_data_i ^ rd_err_i) : rd_data_i;
			end
			if (read_start_i) begin
				for (ri = 0; ri < 8; ri = ri + 1)
					sector_flip_count[ri] <= 4'h0;
			end else if (rd_valid_i && rd_use) begin
				sector_flip_count[rd_sec] <= rd_bad ? `FLIP_UNCORR : rd_sum[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// page summary
	// ----------------------------------------------------------------
	always @* begin
		next_worst_cnt = sector_flip_count[0];
		next_worst_idx = 3'b000;
		// (R17) strict compare keeps the lowest sector on ties
		for (si = 1; si < 8; si = si + 1) begin
			if (sector_flip_count[si] > next_worst_cnt) begin
				next_worst_cnt = sector_flip_count[si];
				next_worst_idx = si[2:0];
			end
		end
		// (R20) three outcomes
		if (next_worst_cnt == `FLIP_UNCORR)
			next_status = `ST_UNCORRECTABLE;
		else if (next_worst_cnt != 4'h0)
			next_status = `ST_CORRECTED;
		else
			next_status = `ST_NO_ERROR;
	end

	always @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ecc_status         <= `ST_NO_ERROR;
			worst_flip_count   <= 4'h0;
			worst_sector_index <= 3'b000;
			sector_flip_flags  <= 8'h00;
		end else begin
			// (R5) result held until another command; a finishing read wins while enabled
			if (rd_done_i && ecc_en) begin
				ecc_status         <= next_status;
				worst_flip_count   <= next_worst_cnt;
				worst_sector_index <= next_worst_idx;
			end else if (cmd_accept_i) begin
				ecc_status <= `ST_NO_ERROR;
			end
			// (R15) flags refresh on buffer output
			if (buf_out_i) begin
				for (fi = 0; fi < 8; fi = fi + 1)
					// (R16) at or above threshold
					sector_flip_flags[fi] <= (sector_flip_count[fi] >= threshold);
			end
		end
	end
endmodule // nand_page_ecc

// [verif/nand_page_ecc_props.sv]
// port checker of the page-buffer correction block
// assumes one clock and the active-low reset of the block
`timescale 1ns/10ps
module nand_page_ecc_props (
	input wire        clk_i,
	input wire        arst_n_i,
	input wire        feat_wr_i,
	input wire        feat_rd_i,
	input wire [7:0]  feat_addr_i,
	input wire [7:0]  feat_wdata_i,
	input wire        feat_rvalid_o,
	input wire        prog_done_i,
	input wire        par_valid_o,
	input wire [12:0] par_col_o,
	input wire        busy_o,
	input wire        rd_valid_i,
	input wire [12:0] rd_col_i,
	input wire [7:0]  rd_data_i,
	input wire        cor_valid_o,
	input wire [12:0] cor_col_o,
	input wire [7:0]  cor_data_o,
	input wire [12:0] host_col_i,
	input wire        host_col_ok_o,
	input wire        ecc_en_o
);
	// ----
	// properties
	// ----
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_read_answer: assert property (feat_rd_i |=> feat_rvalid_o)
		else $error("feature read not answered");
	a_answer_cause: assert property (feat_rvalid_o |-> $past(feat_rd_i))
		else $error("read answer without request");
	a_enable_write: assert property (feat_wr_i && feat_addr_i == 8'hB0 |=> ecc_en_o == $past(feat_wdata_i[4]))
		else $error("enable write not taken");
	a_parity_hidden: assert property (ecc_en_o |-> host_col_ok_o == (host_col_i < 13'h1080))
		else $error("column access wrong while enabled");
	a_spare_wide: assert property (!ecc_en_o |-> host_col_ok_o == (host_col_i < 13'h1100))
		else $error("column access wrong while disabled");
	a_read_echo: assert property (rd_valid_i |=> cor_valid_o && cor_col_o == $past(rd_col_i))
		else $error("read byte not passed on");
	a_raw_disabled: assert property (rd_valid_i && !ecc_en_o |=> cor_data_o == $past(rd_data_i))
		else $error("data altered while disabled");
	a_parity_burst: assert property (prog_done_i && ecc_en_o |-> ##[1:3] par_valid_o [*8])
		else $error("parity burst missing");
	a_parity_cols: assert property (par_valid_o |-> $past(busy_o) && par_col_o >= 13'h1080 && par_col_o < 13'h1100)
		else $error("parity column out of area");
	c_parity: cover property (par_valid_o);
	c_disable: cover property (feat_wr_i && feat_addr_i == 8'hB0 && !feat_wdata_i[4]);
	c_raw: cover property (rd_valid_i && !ecc_en_o);
endmodule // nand_page_ecc_props

bind nand_page_ecc nand_page_ecc_props i_props (.*);

// [verif/feat_host_model.sv]
// host controller model issuing feature writes and reads
// assumes the bench calls its tasks; strobes move 1 ns after an edge
`timescale 1ns/10ps
module feat_host_model (
	input  wire       clk_i,
	input  wire [7:0] feat_rdata_i,
	input  wire       feat_rvalid_i,
	output reg        feat_wr_o,
	output reg        feat_rd_o,
	output reg  [7:0] feat_addr_o,
	output reg  [7:0] feat_wdata_o
);
	// ----
	// feature commands
	// ----
	initial begin
		feat_wr_o = 1'b0;
		feat_rd_o = 1'b0;
		feat_addr_o = 8'h00;
		feat_wdata_o = 8'h00;
	end
	task automatic feat_write(input [7:0] a, input [7:0] d);
		@(posedge clk_i);
		#1 feat_addr_o = a;
		feat_wdata_o = d;
		feat_wr_o = 1'b1;
		@(posedge clk_i);
		#1 feat_wr_o = 1'b0;
		feat_wdata_o = ~d;
	endtask
	task automatic feat_read(input [7:0] a, output [7:0] d);
		@(posedge clk_i);
		#1 feat_addr_o = a;
		feat_rd_o = 1'b1;
		@(posedge clk_i);
		#1 feat_rd_o = 1'b0;
		feat_addr_o = ~a;
		// no answer shows as unknown so every compare fails
		d = feat_rvalid_i ? feat_rdata_i : 8'hxx;
	endtask
endmodule // feat_host_model

// [verif/nand_page_internal_ecc_tb_top.sv]
// self-checking bench of the page-buffer correction block
// assumes the block's constants header and the host model
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module nand_page_internal_ecc_tb_top;
	// ----
	// bench
	// ----
	typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] m;} row_t;
	logic        clk_i = 1'b0, arst_n_i = 1'b0, prog_valid_i = 1'b0, rd_valid_i = 1'b0;
	logic [12:0] prog_col_i = 13'h0000, rd_col_i = 13'h0000, host_col_i = 13'h0000, par_col_o, cor_col_o;
	logic [7:0]  prog_data_i = 8'h00, rd_data_i = 8'h00, rd_err_i = 8'h00, par_data_o, cor_data_o, feat_rdata_o, rd;
	logic        feat_rvalid_o, par_valid_o, busy_o, cor_valid_o, host_col_ok_o, ecc_en_o;
	logic [5:0]  pls = 6'h00;
	wire         feat_wr_i, feat_rd_i;
	wire  [7:0]  feat_addr_i, feat_wdata_i;
	wire         read_start_i = pls[0], rd_done_i = pls[1], buf_out_i = pls[2];
	wire         cmd_accept_i = pls[3], prog_start_i = pls[4], prog_done_i = pls[5];
	int          fail_count = 0, checks = 0;
	row_t        rows [0:12] = '{'{1'b0, 8'h10, 8'h04, 8'h0F}, '{1'b0, 8'hB0, 8'h10, 8'h10},
		'{1'b0, 8'hC0, 8'h00, 8'h30}, '{1'b1, 8'h10, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h04, 8'h0F},
		'{1'b0, 8'h99, 8'h00, 8'hFF}, '{1'b0, 8'h20, 8'h00, 8'hFF}, '{1'b0, 8'hC0, 8'h20, 8'h30},
		'{1'b0, 8'h30, 8'hF2, 8'hFF}, '{1'b0, 8'h40, 8'h23, 8'hFF}, '{1'b0, 8'h41, 8'h0F, 8'hFF},
		'{1'b0, 8'h50, 8'h00, 8'hFF}, '{1'b0, 8'h51, 8'h30, 8'hFF}};

	always #50 clk_i = ~clk_i;
	nand_page_ecc i_dut (.*);
	feat_host_model i_host (.clk_i(clk_i), .feat_rdata_i(feat_rdata_o), .feat_rvalid_i(feat_rvalid_o),
		.feat_wr_o(feat_wr_i), .feat_rd_o(feat_rd_i), .feat_addr_o(feat_addr_i), .feat_wdata_o(feat_wdata_i));

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask
	task automatic pulse(input int k);
		tick();
		pls[k] = 1'b1;
		tick();
		pls = 6'h00;
	endtask
	task automatic give_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic run_rows(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			if (rows[i].wr) i_host.feat_write(rows[i].a, rows[i].d);
			else begin
				i_host.feat_read(rows[i].a, rd);
				`CHK("feature byte", rows[i].d, rd & rows[i].m)
			end
		end
	endtask
	task automatic col_chk(input [12:0] c, input logic e);
		host_col_i = c;
		#1 `CHK("column open", e, host_col_ok_o)
	endtask
	// mode 0 unchecked, 1 corrected, 2 raw
	task automatic rd_byte(input [12:0] c, input [7:0] d, input [7:0] e, input int mode);
		tick();
		rd_valid_i = 1'b1;
		rd_col_i = c;
		rd_data_i = d;
		rd_err_i = e;
		tick();
		rd_valid_i = 1'b0;
		rd_data_i = ~d;
		if (mode != 0) `CHK("read data", (mode == 1) ? d ^ e : d, cor_data_o)
	endtask
	task automatic pr_byte(input [12:0] c, input [7:0] d);
		tick();
		prog_valid_i = 1'b1;
		prog_col_i = c;
		prog_data_i = d;
		tick();
		prog_valid_i = 1'b0;
		prog_data_i = ~d;
	endtask
	task automatic prog_run(input int n, input [7:0] nz_exp);
		int cnt;
		int t;
		logic [7:0] nz;
		cnt = 0;
		nz = 8'h00;
		pulse(4);
		pr_byte(13'h0258, 8'hA5);
		pr_byte(13'h1030, 8'h3C);
		pr_byte(13'h1086, 8'hFF);
		pulse(5);
		for (t = 0; t < 400; t++) begin
			tick();
			if (par_valid_o === 1'b1) begin
				`CHK("parity column", 13'h1080 + cnt[12:0], par_col_o)
				nz[par_col_o[6:4]] = nz[par_col_o[6:4]] | (|par_data_o);
				cnt++;
			end
			if (busy_o !== 1'b1) break;
		end
		if (t == 400) begin
			fail_count++;
			give_verdict();
		end
		`CHK("parity bytes", n, cnt)
		`CHK("sectors with parity", nz_exp, nz)
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		repeat (3) tick();
		run_rows(0, 5);
		for (int c = 1; c < 10; c++) begin
			i_host.feat_write(8'h10, (c == 9) ? 8'h0F : c[7:0]);
			i_host.feat_read(8'h10, rd);
			`CHK("threshold", (c == 9) ? 8'h0F : c[7:0], rd & 8'h0F)
		end
		i_host.feat_write(8'h10, 8'h03);
		col_chk(13'h107F, 1'b1);
		col_chk(13'h1080, 1'b0);
		i_host.feat_write(8'hB0, 8'h10);
		pulse(0);
		rd_byte(13'h0000, 8'h5A, 8'h07, 1);
		rd_byte(13'h0200, 8'h00, 8'h03, 1);
		rd_byte(13'h0400, 8'h0F, 8'hFF, 1);
		rd_byte(13'h1020, 8'h11, 8'h01, 0);
		rd_byte(13'h0FFF, 8'h00, 8'h03, 1);
		rd_byte(13'h1070, 8'h00, 8'h01, 1);
		pulse(1);
		run_rows(6, 12);
		pulse(2);
		i_host.feat_read(8'h20, rd);
		`CHK("sector flags", 8'h85, rd)
		pulse(3);
		i_host.feat_read(8'hC0, rd);
		`CHK("status cleared", 8'h00, rd & 8'h30)
		prog_run(128, 8'h0A);
		i_host.feat_write(8'hB0, 8'h00);
		`CHK("enable", 1'b0, ecc_en_o)
		col_chk(13'h10FF, 1'b1);
		col_chk(13'h1100, 1'b0);
		pulse(0);
		rd_byte(13'h0000, 8'h5A, 8'h07, 2);
		prog_run(0, 8'h00);
		arst_n_i = 1'b0;
		repeat (2) tick();
		arst_n_i = 1'b1;
		repeat (3) tick();
		`CHK("enable after reset", 1'b1, ecc_en_o)
		i_host.feat_read(8'h10, rd);
		`CHK("threshold after reset", 8'h04, rd & 8'h0F)
		pulse(0);
		rd_byte(13'h0200, 8'h00, 8'h01, 1);
		rd_byte(13'h0600, 8'h00, 8'h01, 1);
		pulse(1);
		i_host.feat_read(8'h30, rd);
		`CHK("tie sector", 8'h11, rd)
		i_host.feat_read(8'hC0, rd);
		`CHK("corrected status", 8'h10, rd & 8'h30)
		give_verdict();
	end
endmodule // nand_page_internal_ecc_tb_top
